// [cil_core_irq.sv]
// core interrupt logic: flags, masks, global enable and vectoring
// assumes the core pulses cycle_strobe once per instruction cycle and obeys irq_take
//
// Overview of operation
// - four sources: pin, timer, port change, comparator
// - global enable bit 7 gates all requests
// - reset clears the global enable
// - per-source enable masks its request
// - return instruction sets global enable again
// - pin, port, timer flags in control register
// - comparator flag and enable in peripheral registers
// - taking clears enable, pushes PC, vectors 0004h
// - all flags stay readable for polling
// - pin events vector within three-four cycles
// - flags set regardless of any enable
// - enable clear drops next-cycle vectoring
// - no-operation follows an enable clear
// - dropped requests stay pending until re-enabled
// - only return address saved on entry
// - comparator needs its enable and group enable
// - sleep wake runs PC+1, then vectors only if global enable set
`timescale 1ns/1ps
module cil_core_irq (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // event sources
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_upper_pins,
  input wire logic timer_zero_ovf,
  input wire logic [1:0] cmp_out,
  // mismatch refresh strobes from register reads
  input wire logic port_b_access,
  input wire logic cmp_access,
  // software writes
  input wire cil_pkg::cil_wr_s ctrl_wr,
  input wire cil_pkg::cil_wr_s pflag_wr,
  input wire cil_pkg::cil_wr_s penable_wr,
  // core sequencing
  input wire logic cycle_strobe,
  input wire logic return_from_irq_instr,
  input wire logic sleep_mode,
  // register read-back
  output logic [7:0] irq_control_reg,
  output logic [7:0] periph_flag_reg,
  output logic [7:0] periph_enable_reg,
  // core control
  output logic irq_request,
  output logic irq_take,
  output logic [12:0] irq_vector,
  output logic force_nop,
  output logic wake_up
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [6:0] pins_sync; // {cmp, port_b, ext}

  cil_sync #(.WIDTH(7)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in({cmp_out, port_b_upper_pins, ext_irq_pin}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // event detection state
  // ----------------------------------------------------------------
  logic ext_prev_r, ext_prev_nxt;         // last pin level for edge detect
  logic [3:0] pb_latch_r, pb_latch_nxt;   // port value at last access
  logic [1:0] cmp_latch_r, cmp_latch_nxt; // comparator value at last access
  logic ev_ext, ev_pb, ev_cmp;            // event conditions this cycle

  // edge and mismatch detection, latches refreshed by access strobes
  always_comb begin
    ext_prev_nxt = pins_sync[0];
    pb_latch_nxt = port_b_access ? pins_sync[4:1] : pb_latch_r;
    cmp_latch_nxt = cmp_access ? pins_sync[6:5] : cmp_latch_r;
    ev_ext = pins_sync[0] & ~ext_prev_r;
    ev_pb = (pins_sync[4:1] != pb_latch_r);
    ev_cmp = (pins_sync[6:5] != cmp_latch_r);
  end

  // register event detection state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev_r <= 1'b0;
      pb_latch_r <= 4'h0;
      cmp_latch_r <= 2'h0;
    end else begin
      ext_prev_r <= ext_prev_nxt;
      pb_latch_r <= pb_latch_nxt;
      cmp_latch_r <= cmp_latch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers: enables, flags, global enable
  // ----------------------------------------------------------------
  logic gie_r, gie_nxt;           // global_irq_enable
  logic [6:0] ctrl_r, ctrl_nxt;   // control bits 6..0
  logic cmp_flag_r, cmp_flag_nxt; // cmp_change_flag
  logic cmp_en_r, cmp_en_nxt;     // cmp_change_enable
  logic take_now;                 // vectoring this cycle
  logic gie_clear_ev;             // an instruction clears the enable

  // next register values
  always_comb begin
    // software writes land first, then events or in
    ctrl_nxt = ctrl_wr.en ? ctrl_wr.data[6:0] : ctrl_r;
    ctrl_nxt[cil_pkg::CTRL_INTF_BIT] = ctrl_nxt[cil_pkg::CTRL_INTF_BIT] | ev_ext;
    ctrl_nxt[cil_pkg::CTRL_RBIF_BIT] = ctrl_nxt[cil_pkg::CTRL_RBIF_BIT] | ev_pb;
    ctrl_nxt[cil_pkg::CTRL_T0IF_BIT] = ctrl_nxt[cil_pkg::CTRL_T0IF_BIT] | timer_zero_ovf;
    // comparator flag and enable in peripheral registers
    cmp_flag_nxt = (pflag_wr.en ? pflag_wr.data[cil_pkg::PERIPH_CMP_BIT] : cmp_flag_r) | ev_cmp;
    cmp_en_nxt = penable_wr.en ? penable_wr.data[cil_pkg::PERIPH_CMP_BIT] : cmp_en_r;
    // global enable: write, then return, then taking wins
    gie_nxt = gie_r;
    if (ctrl_wr.en) begin
      gie_nxt = ctrl_wr.data[cil_pkg::CTRL_GIE_BIT];
    end
    if (return_from_irq_instr) begin
      gie_nxt = 1'b1;
    end
    if (take_now) begin
      gie_nxt = 1'b0;
    end
    // instruction-driven clear of a set enable
    gie_clear_ev = gie_r & ctrl_wr.en & ~ctrl_wr.data[cil_pkg::CTRL_GIE_BIT];
  end

  // reset clears global enable and all bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gie_r <= cil_pkg::CTRL_RST[cil_pkg::CTRL_GIE_BIT];
      ctrl_r <= cil_pkg::CTRL_RST[6:0];
      cmp_flag_r <= cil_pkg::PERIPH_RST[cil_pkg::PERIPH_CMP_BIT];
      cmp_en_r <= cil_pkg::PERIPH_RST[cil_pkg::PERIPH_CMP_BIT];
    end else begin
      gie_r <= gie_nxt;
      ctrl_r <= ctrl_nxt;
      cmp_flag_r <= cmp_flag_nxt;
      cmp_en_r <= cmp_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // request combining
  // ----------------------------------------------------------------
  logic src_any; // any enabled source, ignoring global enable
  logic req;     // gated request

  always_comb begin
    // comparator needs its enable and group enable
    src_any = (ctrl_r[cil_pkg::CTRL_T0IE_BIT] & ctrl_r[cil_pkg::CTRL_T0IF_BIT])
            | (ctrl_r[cil_pkg::CTRL_INTE_BIT] & ctrl_r[cil_pkg::CTRL_INTF_BIT])
            | (ctrl_r[cil_pkg::CTRL_RBIE_BIT] & ctrl_r[cil_pkg::CTRL_RBIF_BIT])
            | (ctrl_r[cil_pkg::CTRL_PERIPH_GROUP_ENABLE_BIT] & cmp_en_r & cmp_flag_r);
    req = gie_r & src_any;
  end

  // ----------------------------------------------------------------
  // vectoring sequencer
  // ----------------------------------------------------------------
  cil_pkg::cil_state_e state_r, state_nxt;
  logic armed_r, armed_nxt;       // request seen at previous boundary
  logic suppress_r, suppress_nxt; // next boundary vectoring dropped
  logic take_r, take_nxt;         // one-cycle take pulse
  logic nop_r, nop_nxt;           // no-operation for one instruction
  logic wake_r, wake_nxt;         // wake pulse to core

  // boundary-based arming, take and sleep wake
  always_comb begin
    state_nxt = state_r;
    armed_nxt = armed_r;
    suppress_nxt = suppress_r | gie_clear_ev;
    nop_nxt = nop_r | gie_clear_ev;
    wake_nxt = 1'b0;
    take_now = 1'b0;
    case (state_r)
      cil_pkg::CIL_RUN: begin
        if (sleep_mode) begin
          state_nxt = cil_pkg::CIL_SLEEP;
          armed_nxt = 1'b0;
        end else if (cycle_strobe) begin
          nop_nxt = gie_clear_ev;
          suppress_nxt = 1'b0;
          // drop vectoring after an enable clear
          if (suppress_r || gie_clear_ev) begin
            armed_nxt = 1'b0;
          // armed one boundary, taken at the next
          end else if (armed_r && req) begin
            take_now = 1'b1;
            armed_nxt = 1'b0;
          end else begin
            armed_nxt = req;
          end
        end
      end
      cil_pkg::CIL_SLEEP: begin
        // wake, then PC+1 runs before arming vectors
        if (!sleep_mode) begin
          // core already awake, resume without a second wake pulse
          state_nxt = cil_pkg::CIL_RUN;
        end else if (src_any) begin
          wake_nxt = 1'b1;
          state_nxt = cil_pkg::CIL_RUN;
          armed_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = cil_pkg::CIL_RUN;
      end
    endcase
    take_nxt = take_now;
  end

  // register sequencer state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cil_pkg::CIL_RUN;
      armed_r <= 1'b0;
      suppress_r <= 1'b0;
      take_r <= 1'b0;
      nop_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      armed_r <= armed_nxt;
      suppress_r <= suppress_nxt;
      take_r <= take_nxt;
      nop_r <= nop_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each from flops
  // ----------------------------------------------------------------
  logic req_r; // registered request level
  logic [12:0] vec_r; // vector address, held in a flop like every output

  // register request level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= 1'b0;
      vec_r <= cil_pkg::IRQ_VECTOR;
    end else begin
      req_r <= req;
      vec_r <= cil_pkg::IRQ_VECTOR;
    end
  end

  assign irq_control_reg = {gie_r, ctrl_r};
  assign periph_flag_reg = {1'b0, cmp_flag_r, 6'h00};
  assign periph_enable_reg = {1'b0, cmp_en_r, 6'h00};
  assign irq_request = req_r;
  // take pulse tells core to push PC and load vector
  // no other context is saved here
  assign irq_take = take_r;
  assign irq_vector = vec_r;
  assign force_nop = nop_r;
  assign wake_up = wake_r;

endmodule : cil_core_irq

// [cil_core_irq_properties.sv]
// checker: assertions on the interrupt logic ports
// assumes a bind from the bench top file, one clock domain
`timescale 1ns/1ps
module cil_core_irq_properties (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // watched ports
  input wire logic ext_irq_pin,
  input wire logic cycle_strobe,
  input wire logic return_from_irq_instr,
  input wire logic sleep_mode,
  input wire cil_pkg::cil_wr_s ctrl_wr,
  input wire logic [7:0] irq_control_reg,
  input wire logic [7:0] periph_flag_reg,
  input wire logic irq_request,
  input wire logic irq_take,
  input wire logic [12:0] irq_vector,
  input wire logic force_nop,
  input wire logic wake_up
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_VEC: assert property (irq_vector == 13'h0004)
    else $error("bad vector");
  AST_TAKE_GIE: assert property (irq_take |-> !irq_control_reg[7])
    else $error("enable kept on take");
  AST_TAKE_CAUSE: assert property (irq_take |-> $past(irq_request) && $past(cycle_strobe))
    else $error("take without cause");
  AST_REQ_GIE: assert property (irq_request |-> $past(irq_control_reg[7]))
    else $error("request while disabled");
  AST_GIE_SET: assert property ($rose(irq_control_reg[7]) |-> $past(return_from_irq_instr) || $past(ctrl_wr.en))
    else $error("enable set without cause");
  AST_NOP: assert property ($rose(force_nop) |-> $past(ctrl_wr.en) && !$past(ctrl_wr.data[7]))
    else $error("nop without clearing write");
  AST_SKIP: assert property (force_nop && cycle_strobe |=> !irq_take)
    else $error("take after clearing write");
  AST_WAKE: assert property (wake_up |-> $past(sleep_mode))
    else $error("wake while awake");
  AST_PFLAG: assert property (periph_flag_reg[7] == 1'b0 && periph_flag_reg[5:0] == 6'h00)
    else $error("spare flag bits set");
  AST_INTF: assert property ($rose(ext_irq_pin) |-> ##[1:5] irq_control_reg[1])
    else $error("pin flag not set");
endmodule : cil_core_irq_properties

// [cil_core_irq_tb.sv]
// bench for the core interrupt logic beside a core model
// assumes cil_pkg, cil_core_irq and cil_core_model compiled first
`timescale 1ns/1ps
module cil_core_irq_tb;
  // ----------------------------------------------------------------
  // stimulus, outputs and counters
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic ext_irq_pin = 1'b0;
  logic [3:0] port_b_upper_pins = 4'h0;
  logic timer_zero_ovf = 1'b0;
  logic [1:0] cmp_out = 2'h0;
  logic port_b_access = 1'b0;
  logic cmp_access = 1'b0;
  logic sleep_mode = 1'b0;
  logic ret_cmd = 1'b0;
  cil_pkg::cil_wr_s ctrl_wr = '0;
  cil_pkg::cil_wr_s pflag_wr = '0;
  cil_pkg::cil_wr_s penable_wr = '0;
  logic cycle_strobe, return_from_irq_instr, irq_request, irq_take, force_nop, wake_up;
  logic [7:0] irq_control_reg, periph_flag_reg, periph_enable_reg;
  logic [12:0] irq_vector, pc, stack_top;
  int err_total = 0;
  int checks_done = 0;
  int takes = 0;
  logic [7:0] en_t [4] = '{8'h90, 8'ha0, 8'h88, 8'hc0}; // enables per source
  logic [7:0] fl_t [4] = '{8'h02, 8'h04, 8'h01, 8'h00}; // flags per source
  always #12.5 clock = ~clock;
  // count vectoring pulses
  always @(posedge clock) if (irq_take === 1'b1) takes++;
  cil_core_irq i_dut (.clock(clock), .arst_n(arst_n), .ext_irq_pin(ext_irq_pin),
    .port_b_upper_pins(port_b_upper_pins), .timer_zero_ovf(timer_zero_ovf), .cmp_out(cmp_out),
    .port_b_access(port_b_access), .cmp_access(cmp_access), .ctrl_wr(ctrl_wr), .pflag_wr(pflag_wr),
    .penable_wr(penable_wr), .cycle_strobe(cycle_strobe), .return_from_irq_instr(return_from_irq_instr),
    .sleep_mode(sleep_mode), .irq_control_reg(irq_control_reg), .periph_flag_reg(periph_flag_reg),
    .periph_enable_reg(periph_enable_reg), .irq_request(irq_request), .irq_take(irq_take),
    .irq_vector(irq_vector), .force_nop(force_nop), .wake_up(wake_up));
  cil_core_model i_core (.clock(clock), .arst_n(arst_n), .irq_take(irq_take), .irq_vector(irq_vector),
    .ret_cmd(ret_cmd), .cycle_strobe(cycle_strobe), .return_from_irq_instr(return_from_irq_instr),
    .pc(pc), .stack_top(stack_top));
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one write strobe: 0 control, 1 flags, 2 enables
  task automatic wr(input int sel, input logic [7:0] d);
    cil_pkg::cil_wr_s w;
    w = '{en: 1'b1, data: d};
    if (sel == 0) ctrl_wr <= w;
    else if (sel == 1) pflag_wr <= w;
    else penable_wr <= w;
    @(posedge clock);
    ctrl_wr.en <= 1'b0;
    pflag_wr.en <= 1'b0;
    penable_wr.en <= 1'b0;
    @(posedge clock);
  endtask : wr
  // bounded wait for take or wake
  task automatic wait_for(input bit wake, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(negedge clock);
      cyc++;
      if (cyc > lim) begin
        err_total++;
        $display("BAD %0t no response", $time);
        end_sim();
      end
    end while ((wake ? wake_up : irq_take) !== 1'b1);
  endtask : wait_for
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    int cyc;
    int t0;
    cyc = $urandom(32'h6ba8);
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk({irq_control_reg, periph_enable_reg}, 16'h0000);
    chk({3'h0, irq_vector}, 16'h0004);
    @(posedge clock);
    timer_zero_ovf <= 1'b1;
    @(posedge clock);
    timer_zero_ovf <= 1'b0;
    repeat (20) @(posedge clock);
    chk({irq_control_reg, 8'(takes)}, 16'h0400);
    // each source vectors once, at a random phase
    for (int s = 0; s < 4; s++) begin
      wr(0, 8'h00);
      if (s == 3) wr(2, 8'h40);
      wr(0, en_t[s]);
      repeat ($urandom_range(3, 0)) @(posedge clock);
      t0 = takes;
      case (s)
        0: ext_irq_pin <= 1'b1;
        1: timer_zero_ovf <= 1'b1;
        2: port_b_upper_pins <= 4'($urandom_range(15, 1));
        default: cmp_out <= 2'($urandom_range(3, 1));
      endcase
      @(posedge clock);
      timer_zero_ovf <= 1'b0;
      wait_for(1'b0, 40, cyc);
      chk(16'(cyc <= 17), 16'h0001);
      chk({irq_control_reg & 8'h87, periph_flag_reg}, {fl_t[s], (s == 3) ? 8'h40 : 8'h00});
      @(negedge clock);
      chk({3'h0, pc}, 16'h0004);
      @(posedge clock);
      port_b_access <= 1'b1;
      cmp_access <= 1'b1;
      @(posedge clock);
      port_b_access <= 1'b0;
      cmp_access <= 1'b0;
      ext_irq_pin <= 1'b0;
      wr(1, 8'h00);
      wr(0, en_t[s] & 8'h78);
      ret_cmd <= 1'b1;
      @(posedge clock);
      ret_cmd <= 1'b0;
      repeat (20) @(posedge clock);
      chk({irq_control_reg[7], 7'h0, 8'(takes - t0)}, 16'h8001);
    end
    // masked timer and comparator events set flags but never request
    t0 = takes;
    wr(0, 8'h80);
    timer_zero_ovf <= 1'b1;
    cmp_out <= cmp_out ^ 2'h1;
    @(posedge clock);
    timer_zero_ovf <= 1'b0;
    repeat (20) @(posedge clock);
    chk({irq_control_reg, 7'h0, irq_request}, 16'h8400);
    chk({periph_enable_reg, periph_flag_reg}, 16'h4040);
    chk(16'(takes - t0), 16'h0000);
    wr(0, 8'h10);
    t0 = takes;
    ext_irq_pin <= 1'b1;
    repeat (20) @(posedge clock);
    chk({irq_control_reg, 8'(takes - t0)}, 16'h1200);
    chk({15'h0, irq_request}, 16'h0000);
    wr(0, 8'h92);
    wait_for(1'b0, 40, cyc);
    chk({irq_control_reg, 8'h00}, 16'h1200);
    @(posedge clock);
    ret_cmd <= 1'b1;
    @(posedge clock);
    ret_cmd <= 1'b0;
    @(posedge clock);
    wr(0, 8'h12);
    repeat (20) @(posedge clock);
    chk({irq_control_reg, 8'(takes - t0)}, 16'h1201);
    // wake from sleep with the global enable off
    wr(0, 8'h10);
    ext_irq_pin <= 1'b0;
    sleep_mode <= 1'b1;
    repeat (4) @(posedge clock);
    ext_irq_pin <= 1'b1;
    wait_for(1'b1, 20, cyc);
    @(posedge clock);
    sleep_mode <= 1'b0;
    repeat (8) @(posedge clock);
    chk({irq_control_reg, 8'(takes - t0)}, 16'h1201);
    // wake with the global enable on: one instruction, then the vector
    ext_irq_pin <= 1'b0;
    wr(0, 8'h90);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge clock);
    ext_irq_pin <= 1'b1;
    wait_for(1'b1, 20, cyc);
    @(posedge clock);
    sleep_mode <= 1'b0;
    wait_for(1'b0, 40, cyc);
    @(negedge clock);
    chk({irq_control_reg, 8'(takes - t0)}, 16'h1202);
    chk({3'h0, pc}, 16'h0004);
    end_sim();
  end
endmodule : cil_core_irq_tb
bind cil_core_irq cil_core_irq_properties i_props (.clock(clock), .arst_n(arst_n), .ext_irq_pin(ext_irq_pin),
  .cycle_strobe(cycle_strobe), .return_from_irq_instr(return_from_irq_instr), .sleep_mode(sleep_mode),
  .ctrl_wr(ctrl_wr), .irq_control_reg(irq_control_reg), .periph_flag_reg(periph_flag_reg),
  .irq_request(irq_request), .irq_take(irq_take), .irq_vector(irq_vector), .force_nop(force_nop),
  .wake_up(wake_up));

// [cil_core_model.sv]
// behavioural core: instruction cycle strobe, pc and stack
// assumes the bench pulses ret_cmd for one clock
`timescale 1ns/1ps
module cil_core_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // from the interrupt logic
  input wire logic irq_take,
  input wire logic [12:0] irq_vector,
  // bench command for the return instruction
  input wire logic ret_cmd,
  // sequencing and state
  output logic cycle_strobe,
  output logic return_from_irq_instr,
  output logic [12:0] pc,
  output logic [12:0] stack_top
);
  logic [1:0] q_cnt; // quarter clocks of one instruction cycle
  // quarter counter, pc and one-deep stack
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_cnt <= 2'h0;
      cycle_strobe <= 1'b0;
      return_from_irq_instr <= 1'b0;
      pc <= 13'h0000;
      stack_top <= 13'h0000;
    end else begin
      q_cnt <= q_cnt + 2'h1;
      cycle_strobe <= (q_cnt == 2'h2);
      return_from_irq_instr <= ret_cmd;
      if (irq_take) begin
        stack_top <= pc;
        pc <= irq_vector;
      end else if (return_from_irq_instr) begin
        pc <= stack_top;
      end else if (cycle_strobe) begin
        pc <= pc + 13'h0001;
      end
    end
  end
endmodule : cil_core_model

// [cil_pkg.sv]
// package of constants and carriers for the core interrupt logic
// assumes one core clock; instruction cycle boundaries are marked by the core
package cil_pkg;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GIE_BIT = 7;   // global_irq_enable
  localparam int unsigned CTRL_PERIPH_GROUP_ENABLE_BIT = 6;  // periph_group_enable
  localparam int unsigned CTRL_T0IE_BIT = 5;  // timer_zero overflow enable
  localparam int unsigned CTRL_INTE_BIT = 4;  // ext_irq_pin enable
  localparam int unsigned CTRL_RBIE_BIT = 3;  // port_b_upper_pins change enable
  localparam int unsigned CTRL_T0IF_BIT = 2;  // timer_zero overflow flag
  localparam int unsigned CTRL_INTF_BIT = 1;  // ext_irq_pin flag
  localparam int unsigned CTRL_RBIF_BIT = 0;  // port change flag

  // ----------------------------------------------------------------
  // peripheral flag / enable field positions
  // ----------------------------------------------------------------
  localparam int unsigned PERIPH_CMP_BIT = 6; // cmp_change_flag / cmp_change_enable

  // ----------------------------------------------------------------
  // reset values and vector
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam int unsigned SYNC_STAGES = 2;

  // software write carrier: strobe plus byte
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } cil_wr_s;

  // vectoring sequencer states
  typedef enum logic [0:0] {
    CIL_RUN,
    CIL_SLEEP
  } cil_state_e;

endpackage : cil_pkg

// [cil_sync.sv]
// two-flop synchroniser bank for asynchronous pin levels
// assumes a single destination clock and async active-low reset
`timescale 1ns/1ps
module cil_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // async levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // per-bit two stage chain
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta_r; // first stage, read only by second stage
      logic hold_r; // second stage
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[gi];
          hold_r <= meta_r;
        end
      end
      assign sync_out[gi] = hold_r;
    end
  endgenerate

endmodule : cil_sync
